//--- uart_multidrop_pkg.sv
`default_nettype none
package uart_multidrop_pkg;
    // Register word addresses
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_STATUS_A = 3'h1;
    localparam logic [2:0] ADDR_CONTROL_B = 3'h2;
    localparam logic [2:0] ADDR_SHARED = 3'h3;
    localparam logic [2:0] ADDR_BAUD_LOW = 3'h4;
    // Status A fields
    localparam int SA_RXC = 7;
    localparam int SA_TXC = 6;
    localparam int SA_TX_BUFFER_EMPTY_FLAG = 5;
    localparam int SA_FILTER = 0;
    // Control B fields
    localparam int CB_RXIE = 7;
    localparam int CB_TXIE = 6;
    localparam int CB_UDIE = 5;
    localparam int CB_RXEN = 4;
    localparam int CB_TXEN = 3;
    localparam int CB_SIZE2 = 2;
    localparam int CB_RX9 = 1;
    localparam int CB_TX9 = 0;
    // Frame format fields and reset
    localparam int FF_SEL = 7;
    localparam int FF_STOP = 3;
    localparam int FF_SIZE_HI = 2;
    localparam int FF_SIZE_LO = 1;
    localparam logic [6:0] FF_RESET = 7'h06;
    localparam logic [2:0] SIZE_NINE = 3'h7;
    localparam logic [3:0] BITS_NINE = 4'h9;
    localparam logic [3:0] BITS_BASE = 4'h5;
    localparam logic [11:0] BAUD_RESET = 12'h000;

    typedef struct packed {
        logic [8:0] data;
        logic stop1;
    } rx_frame_type;

    typedef struct packed {
        logic [8:0] data;
        logic [3:0] n_bits;
        logic two_stop;
    } tx_req_type;

    typedef enum logic [1:0] {PH_IDLE, PH_START, PH_BITS, PH_STOP} phase_type;

    // Data bits per character from the size code
    function automatic logic [3:0] char_bits(input logic [2:0] code);
        if (code == SIZE_NINE)
            return BITS_NINE;
        return BITS_BASE + {2'h0, code[1:0]};
    endfunction
endpackage
`default_nettype wire

//--- uart_rx_deser.sv
`timescale 1ns/1ps
`default_nettype none
module uart_rx_deser (
    input wire logic clk_sys,
    input wire logic rst_sync_n,
    input wire logic enable,
    input wire logic rxd_pin,
    input wire logic [11:0] bit_period,
    input wire logic [3:0] n_bits,
    output var uart_multidrop_pkg::rx_frame_type frame,
    output logic frame_valid
);
    typedef struct packed {
        logic [2:0] sync;
        logic level;
        uart_multidrop_pkg::phase_type phase;
        logic [11:0] cnt;
        logic [3:0] idx;
        uart_multidrop_pkg::rx_frame_type frame;
        logic valid;
    } rx_state_type;

    rx_state_type st;
    rx_state_type next_st;

    always_comb
    begin
        next_st = st;
        next_st.valid = 1'b0;
        next_st.sync = {st.sync[1:0], rxd_pin};
        if (st.sync[1] == st.sync[2])
            next_st.level = st.sync[2];
        case (st.phase)
            uart_multidrop_pkg::PH_IDLE:
                if (enable && !st.level)
                begin
                    next_st.phase = uart_multidrop_pkg::PH_START;
                    next_st.cnt = {1'b0, bit_period[11:1]};
                end
            uart_multidrop_pkg::PH_START:
                if (st.cnt != 12'h000)
                    next_st.cnt = st.cnt - 12'h001;
                else if (st.level)
                    next_st.phase = uart_multidrop_pkg::PH_IDLE;
                else
                begin
                    next_st.phase = uart_multidrop_pkg::PH_BITS;
                    next_st.cnt = bit_period;
                    next_st.idx = 4'h0;
                    next_st.frame.data = 9'h000;
                end
            uart_multidrop_pkg::PH_BITS:
                if (st.cnt != 12'h000)
                    next_st.cnt = st.cnt - 12'h001;
                else
                begin
                    // Unused upper bits stay zero
                    next_st.frame.data[st.idx] = st.level; // RL15
                    next_st.cnt = bit_period;
                    next_st.idx = st.idx + 4'h1;
                    if (st.idx == n_bits - 4'h1)
                        next_st.phase = uart_multidrop_pkg::PH_STOP;
                end
            uart_multidrop_pkg::PH_STOP:
                if (st.cnt != 12'h000)
                    next_st.cnt = st.cnt - 12'h001;
                else
                begin
                    // Only the first stop bit is sampled
                    next_st.frame.stop1 = st.level; // RL3
                    next_st.valid = 1'b1;
                    next_st.phase = uart_multidrop_pkg::PH_IDLE;
                end
            default:
                next_st.phase = uart_multidrop_pkg::PH_IDLE;
        endcase
        if (!enable)
            next_st.phase = uart_multidrop_pkg::PH_IDLE;
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            st <= '0;
            st.sync <= 3'h7;
            st.level <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign frame = st.frame;
    assign frame_valid = st.valid;

    a_rx_upper_zero: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // RL15
        frame_valid |-> (frame.data >> n_bits) == 9'h000)
        else $error("Unused receive bits not zero");
endmodule
`default_nettype wire

//--- uart_tx_ser.sv
`timescale 1ns/1ps
`default_nettype none
module uart_tx_ser (
    input wire logic clk_sys,
    input wire logic rst_sync_n,
    input wire logic start,
    input wire uart_multidrop_pkg::tx_req_type req,
    input wire logic [11:0] bit_period,
    output logic txd,
    output logic busy,
    output logic done
);
    typedef struct packed {
        uart_multidrop_pkg::phase_type phase;
        logic [11:0] cnt;
        logic [3:0] idx;
        logic [3:0] n_bits;
        logic [8:0] shreg;
        logic second_stop;
        logic txd;
        logic done;
    } tx_state_type;

    tx_state_type st;
    tx_state_type next_st;

    always_comb
    begin
        next_st = st;
        next_st.done = 1'b0;
        case (st.phase)
            uart_multidrop_pkg::PH_IDLE:
            begin
                next_st.txd = 1'b1;
                if (start)
                begin
                    next_st.shreg = req.data;
                    next_st.n_bits = req.n_bits;
                    next_st.second_stop = req.two_stop;
                    next_st.txd = 1'b0;
                    next_st.cnt = bit_period;
                    next_st.phase = uart_multidrop_pkg::PH_START;
                end
            end
            uart_multidrop_pkg::PH_START, uart_multidrop_pkg::PH_BITS:
                if (st.cnt != 12'h000)
                    next_st.cnt = st.cnt - 12'h001;
                else
                begin
                    next_st.cnt = bit_period;
                    if (st.phase == uart_multidrop_pkg::PH_START)
                        next_st.idx = 4'h0;
                    if (st.phase == uart_multidrop_pkg::PH_BITS && st.idx == st.n_bits)
                    begin
                        next_st.txd = 1'b1;
                        next_st.phase = uart_multidrop_pkg::PH_STOP;
                    end
                    else
                    begin
                        // Bits above the character size are never sent
                        next_st.txd = st.shreg[0]; // RL15
                        next_st.shreg = {1'b0, st.shreg[8:1]};
                        next_st.idx = (st.phase == uart_multidrop_pkg::PH_START) ?
                            4'h1 : st.idx + 4'h1;
                        next_st.phase = uart_multidrop_pkg::PH_BITS;
                    end
                end
            uart_multidrop_pkg::PH_STOP:
                if (st.cnt != 12'h000)
                    next_st.cnt = st.cnt - 12'h001;
                else if (st.second_stop)
                begin
                    next_st.second_stop = 1'b0;
                    next_st.cnt = bit_period;
                end
                else
                begin
                    next_st.phase = uart_multidrop_pkg::PH_IDLE;
                    next_st.done = 1'b1;
                end
            default:
                next_st.phase = uart_multidrop_pkg::PH_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            st <= '0;
            st.txd <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign txd = st.txd;
    assign busy = st.phase != uart_multidrop_pkg::PH_IDLE;
    assign done = st.done;

    a_tx_start_low: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // RL17
        start && !busy |=> !txd && busy)
        else $error("Start bit not driven");
endmodule
`default_nettype wire

//--- uart_multidrop_regs.sv
// Overview of operation
// (RL1) With filtering on, frames without address marking are dropped, never buffered.
// (RL2) Transmitter ignores the filter bit entirely.
// (RL3) For 5 to 8 data bits, first stop bit marks frame type.
// (RL4) For nine data bits, received ninth bit marks frame type.
// (RL5) Type one means address frame, type zero means data frame.
// (RL6) Master and slaves use nine-bit characters; ninth bit high marks address.
// (RL7) Address frames under filtering are stored and raise receive-complete normally.
// (RL8) Selected slave clears filter, takes data, sets filter again afterwards.
// (RL9) Short characters with filtering need two stop bits at the sender.
// (RL10) Software avoids bit set/clear instructions on the filter bit.
// (RL11) Shared location write: top bit picks baud high or frame format.
// (RL12) Shared read gives baud high; after a read just before, frame format.
// (RL13) Software keeps the two-read frame format sequence uninterrupted.
// (RL14) Data location writes fill transmit buffer; reads return receive buffer.
// (RL15) Unused upper bits ignored on transmit and read as zero on receive.
// (RL16) Data writes while buffer-empty flag is clear are ignored.
// (RL17) Buffered data moves into an empty shifter and goes out serially.
// (RL18) Receive buffer is a two-entry FIFO advanced by data location reads.
// (RL19) Status bit 7 shows unread data; disabling receiver flushes it.
// (RL20) Status bit 6 sets after frame out with empty buffer; cleared by ack or one.
// (RL21) Status bit 5 shows transmit buffer empty, and is one after reset.
// (RL22) Each of the three flags drives its own enabled interrupt request.
// (RL23) Discarded data frames leave FIFO and receive flags untouched.
`timescale 1ns/1ps
`default_nettype none
module uart_multidrop_regs (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic rxd_pin,
    output logic txd_pin,
    output logic txd_oe,
    input wire logic tx_done_irq_ack,
    output logic irq_rx_complete,
    output logic irq_tx_done,
    output logic irq_tx_empty
);
    typedef struct packed {
        logic multidrop_filter_enable;
        logic tx_done_flag;
        logic rx_complete_irq_en;
        logic tx_done_irq_en;
        logic tx_empty_irq_en;
        logic rx_en;
        logic tx_en;
        logic size2;
        logic tx_ninth_bit;
        logic [6:0] frame_format;
        logic [3:0] baud_div_high;
        logic [7:0] baud_div_low;
        logic [8:0] tx_data_buffer;
        logic tx_buffer_full;
        logic [1:0][8:0] rx_data_buffer;
        logic rd_ptr;
        logic [1:0] count;
        logic prev_shared_rd;
        logic [7:0] rdata;
    } regs_type;

    regs_type st;
    regs_type next_st;
    logic [1:0] rst_pipe;
    logic rst_sync_n;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            rst_pipe <= 2'h0;
        else
            rst_pipe <= {rst_pipe[0], 1'b1};
    end
    assign rst_sync_n = rst_pipe[1];

    ////////////////////////////////////////////////////////////////////////////
    // Serial engines
    logic [2:0] size_code;
    logic [3:0] n_bits;
    logic [11:0] bit_period;
    uart_multidrop_pkg::rx_frame_type rx_frame;
    logic rx_valid;
    uart_multidrop_pkg::tx_req_type tx_req;
    logic tx_load;
    logic tx_busy;
    logic tx_done;

    assign size_code = {st.size2, st.frame_format[uart_multidrop_pkg::FF_SIZE_HI:
        uart_multidrop_pkg::FF_SIZE_LO]};
    assign n_bits = uart_multidrop_pkg::char_bits(size_code); // RL6
    assign bit_period = {st.baud_div_high, st.baud_div_low};

    // Filter bit deliberately absent from the transmit path
    assign tx_req = '{data: st.tx_data_buffer, n_bits: n_bits, // RL2
        two_stop: st.frame_format[uart_multidrop_pkg::FF_STOP]};
    assign tx_load = st.tx_en && st.tx_buffer_full && !tx_busy; // RL17

    uart_rx_deser u_rx (
        .clk_sys(clk_sys),
        .rst_sync_n(rst_sync_n),
        .enable(st.rx_en),
        .rxd_pin(rxd_pin),
        .bit_period(bit_period),
        .n_bits(n_bits),
        .frame(rx_frame),
        .frame_valid(rx_valid)
    );

    uart_tx_ser u_tx (
        .clk_sys(clk_sys),
        .rst_sync_n(rst_sync_n),
        .start(tx_load),
        .req(tx_req),
        .bit_period(bit_period),
        .txd(txd_pin),
        .busy(tx_busy),
        .done(tx_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Frame filtering and receive FIFO
    logic type_bit;
    logic accept;
    logic data_rd;
    logic data_wr;
    logic shared_rd;
    logic pop;
    logic rx_complete_flag;
    logic tx_buffer_empty_flag;
    logic [8:0] rx_head;

    assign type_bit = (size_code == uart_multidrop_pkg::SIZE_NINE) ? // RL4
        rx_frame.data[8] : rx_frame.stop1; // RL3
    // One marks address, zero marks data
    assign accept = rx_valid && st.rx_en // RL5
        && !(st.multidrop_filter_enable && !type_bit) // RL1 RL23
        && (st.count != 2'h2 || pop); // RL7
    assign data_rd = rd_en && addr == uart_multidrop_pkg::ADDR_DATA;
    assign data_wr = wr_en && addr == uart_multidrop_pkg::ADDR_DATA;
    assign shared_rd = rd_en && addr == uart_multidrop_pkg::ADDR_SHARED;
    assign pop = data_rd && st.count != 2'h0; // RL18
    assign rx_complete_flag = st.count != 2'h0; // RL19
    assign tx_buffer_empty_flag = !st.tx_buffer_full; // RL21
    assign rx_head = st.rx_data_buffer[st.rd_ptr];

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    always_comb
    begin
        next_st = st;
        next_st.rdata = 8'h00;
        next_st.prev_shared_rd = shared_rd;
        if (rd_en)
            case (addr)
                uart_multidrop_pkg::ADDR_DATA:
                    next_st.rdata = rx_head[7:0]; // RL14
                uart_multidrop_pkg::ADDR_STATUS_A:
                begin
                    next_st.rdata[uart_multidrop_pkg::SA_RXC] = rx_complete_flag; // RL19
                    next_st.rdata[uart_multidrop_pkg::SA_TXC] = st.tx_done_flag;
                    next_st.rdata[uart_multidrop_pkg::SA_TX_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag;
                    next_st.rdata[uart_multidrop_pkg::SA_FILTER] =
                        st.multidrop_filter_enable;
                end
                uart_multidrop_pkg::ADDR_CONTROL_B:
                    next_st.rdata = {st.rx_complete_irq_en, st.tx_done_irq_en,
                        st.tx_empty_irq_en, st.rx_en, st.tx_en, st.size2,
                        rx_head[8], st.tx_ninth_bit};
                uart_multidrop_pkg::ADDR_SHARED:
                    if (st.prev_shared_rd)
                        next_st.rdata = {1'b1, st.frame_format}; // RL12
                    else
                        next_st.rdata = {4'h0, st.baud_div_high}; // RL12
                uart_multidrop_pkg::ADDR_BAUD_LOW:
                    next_st.rdata = st.baud_div_low;
                default:
                    next_st.rdata = 8'h00;
            endcase
        if (wr_en)
            case (addr)
                uart_multidrop_pkg::ADDR_DATA:
                    if (tx_buffer_empty_flag) // RL16
                    begin
                        next_st.tx_data_buffer = {st.tx_ninth_bit, wdata}; // RL14
                        next_st.tx_buffer_full = 1'b1;
                    end
                uart_multidrop_pkg::ADDR_STATUS_A:
                begin
                    next_st.multidrop_filter_enable = wdata[uart_multidrop_pkg::SA_FILTER];
                    if (wdata[uart_multidrop_pkg::SA_TXC])
                        next_st.tx_done_flag = 1'b0; // RL20
                end
                uart_multidrop_pkg::ADDR_CONTROL_B:
                begin
                    next_st.rx_complete_irq_en = wdata[uart_multidrop_pkg::CB_RXIE];
                    next_st.tx_done_irq_en = wdata[uart_multidrop_pkg::CB_TXIE];
                    next_st.tx_empty_irq_en = wdata[uart_multidrop_pkg::CB_UDIE];
                    next_st.rx_en = wdata[uart_multidrop_pkg::CB_RXEN];
                    next_st.tx_en = wdata[uart_multidrop_pkg::CB_TXEN];
                    next_st.size2 = wdata[uart_multidrop_pkg::CB_SIZE2];
                    next_st.tx_ninth_bit = wdata[uart_multidrop_pkg::CB_TX9];
                end
                uart_multidrop_pkg::ADDR_SHARED:
                    if (wdata[uart_multidrop_pkg::FF_SEL])
                        next_st.frame_format = wdata[6:0]; // RL11
                    else
                        next_st.baud_div_high = wdata[3:0]; // RL11
                uart_multidrop_pkg::ADDR_BAUD_LOW:
                    next_st.baud_div_low = wdata;
                default:
                    next_st.frame_format = st.frame_format;
            endcase
        if (tx_done_irq_ack)
            next_st.tx_done_flag = 1'b0; // RL20
        // Set wins over a same-cycle clear
        if (tx_done && !st.tx_buffer_full)
            next_st.tx_done_flag = 1'b1; // RL20
        if (tx_load)
            next_st.tx_buffer_full = 1'b0; // RL17
        if (pop)
            next_st.rd_ptr = !st.rd_ptr; // RL18
        if (accept)
            next_st.rx_data_buffer[st.rd_ptr ^ st.count[0]] = rx_frame.data; // RL7
        next_st.count = st.count + {1'b0, accept} - {1'b0, pop};
        if (!st.rx_en)
        begin
            next_st.count = 2'h0; // RL19
            next_st.rd_ptr = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            st <= '0;
            st.frame_format <= uart_multidrop_pkg::FF_RESET;
            st.baud_div_high <= uart_multidrop_pkg::BAUD_RESET[11:8];
            st.baud_div_low <= uart_multidrop_pkg::BAUD_RESET[7:0];
        end
        else
            st <= next_st;
    end

    assign rdata = st.rdata;
    // Pin stays claimed while tx_en is set or until the frame in the shifter has left
    assign txd_oe = st.tx_en || tx_busy;
    assign irq_rx_complete = rx_complete_flag && st.rx_complete_irq_en; // RL22
    assign irq_tx_done = st.tx_done_flag && st.tx_done_irq_en; // RL22
    assign irq_tx_empty = tx_buffer_empty_flag && st.tx_empty_irq_en; // RL22

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_sync_n);

    sequence s_shared_rd;
        rd_en && addr == uart_multidrop_pkg::ADDR_SHARED;
    endsequence

    sequence s_ff_pair;
        s_shared_rd ##1 s_shared_rd;
    endsequence

    a_filter_drop: assert property ( // RL1
        rx_valid && st.rx_en && st.multidrop_filter_enable && !type_bit && !data_rd
        |=> $stable(st.count))
        else $error("Filtered data frame changed FIFO");
    a_address_store: assert property ( // RL7
        rx_valid && st.rx_en && type_bit && st.count == 2'h0 |=> rx_complete_flag)
        else $error("Address frame not stored");
    a_shared_format: assert property ( // RL12
        s_ff_pair |=> st.rdata == {1'b1, $past(st.frame_format)})
        else $error("Second shared read not frame format");
    a_shared_baud: assert property ( // RL12
        s_shared_rd and !$past(shared_rd) |=> st.rdata == {4'h0, $past(st.baud_div_high)})
        else $error("Single shared read not baud high");
    a_shared_write: assert property ( // RL11
        wr_en && addr == uart_multidrop_pkg::ADDR_SHARED && wdata[7]
        |=> st.frame_format == $past(wdata[6:0]))
        else $error("Frame format write lost");
    a_full_write_ignored: assert property ( // RL16
        data_wr && st.tx_buffer_full |=> st.tx_data_buffer == $past(st.tx_data_buffer))
        else $error("Write into full buffer taken");
    a_buffer_fill: assert property ( // RL14
        data_wr && !st.tx_buffer_full |=> st.tx_buffer_full
        && st.tx_data_buffer[7:0] == $past(wdata))
        else $error("Data write not buffered");
    a_empty_status: assert property ( // RL21
        rd_en && addr == uart_multidrop_pkg::ADDR_STATUS_A
        |=> st.rdata[uart_multidrop_pkg::SA_TX_BUFFER_EMPTY_FLAG] == !$past(st.tx_buffer_full))
        else $error("Empty flag misreported");
    a_done_set: assert property ( // RL20
        tx_done && !st.tx_buffer_full |=> st.tx_done_flag)
        else $error("Transmit done flag not set");
    a_rx_flush: assert property ( // RL19
        !st.rx_en |=> !rx_complete_flag)
        else $error("Receive buffer not flushed");
    a_fifo_pop: assert property ( // RL18
        pop && !accept && st.rx_en |=> st.count == $past(st.count) - 2'h1)
        else $error("FIFO did not advance on read");
    a_shift_load: assert property ( // RL17
        tx_load |=> tx_busy && !st.tx_buffer_full)
        else $error("Buffered data not loaded");
endmodule
`default_nettype wire

//--- uart_node_model.sv
`timescale 1ns/1ps
`default_nettype none
module uart_node_model #(parameter int BT = 16) (
    input wire logic clk_sys,
    input wire logic txd_pin,
    output logic rxd
);
    logic [8:0] got[$];
    logic [8:0] sh;
    initial rxd = 1'b1;
    ////////////////////////////////////////
    task automatic send(input logic [8:0] d, input int nb, input logic t);
        rxd <= 1'b0;
        repeat (BT) @(posedge clk_sys);
        for (int i = 0; i < nb; i++)
        begin
            rxd <= d[i];
            repeat (BT) @(posedge clk_sys);
        end
        rxd <= (nb == 9) ? 1'b1 : t;
        repeat (BT) @(posedge clk_sys);
        rxd <= 1'b1;
        repeat (2 * BT) @(posedge clk_sys);
    endtask
    ////////////////////////////////////////
    initial
    forever
    begin
        @(negedge txd_pin);
        repeat (BT / 2) @(posedge clk_sys);
        for (int i = 0; i < 9; i++)
        begin
            repeat (BT) @(posedge clk_sys);
            sh[i] = txd_pin;
        end
        got.push_back(sh);
    end
endmodule
`default_nettype wire

//--- uart_multidrop_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module uart_multidrop_regs_bench;
    typedef struct packed {
        logic [7:0] cb, ff, filt;
        logic [8:0] d;
        logic [3:0] nb;
        logic t, keep;
        logic [7:0] exp;
    } row_type;
    row_type rows[6] = '{
        '{8'h14, 8'h86, 8'h01, 9'h033, 4'h9, 1'b0, 1'b0, 8'h00},
        '{8'h14, 8'h86, 8'h01, 9'h15A, 4'h9, 1'b1, 1'b1, 8'h5A},
        '{8'h14, 8'h86, 8'h00, 9'h033, 4'h9, 1'b0, 1'b1, 8'h33},
        '{8'h10, 8'h86, 8'h01, 9'h0A5, 4'h8, 1'b0, 1'b0, 8'h00},
        '{8'h10, 8'h86, 8'h01, 9'h0A5, 4'h8, 1'b1, 1'b1, 8'hA5},
        '{8'h10, 8'h80, 8'h00, 9'h0FF, 4'h5, 1'b1, 1'b1, 8'h1F}};
    logic clk_sys = 1'b0, resetn = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic rxd_pin, txd_pin;
    logic tx_done_irq_ack = 1'b0, txd_oe, irq_rx_complete, irq_tx_done, irq_tx_empty;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata;
    int num_errors = 0, samples_checked = 0;
    initial forever #10 clk_sys = ~clk_sys;
    uart_node_model #(.BT(16)) node (.clk_sys(clk_sys), .txd_pin(txd_pin), .rxd(rxd_pin));
    uart_multidrop_regs dut (.clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
        .txd_oe(txd_oe), .tx_done_irq_ack(tx_done_irq_ack),
        .irq_rx_complete(irq_rx_complete), .irq_tx_done(irq_tx_done),
        .irq_tx_empty(irq_tx_empty));
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #400000;
        num_errors++;
        end_of_test();
    end
    ////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(3'h1, 8'h20);
        rd(3'h5, 8'h00);
        @(posedge clk_sys);
        addr <= 3'h3;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        #1 chk(rdata, 8'h00);
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 chk(rdata, 8'h86);
        wr(3'h3, 8'h01);
        rd(3'h3, 8'h01);
        wr(3'h3, 8'h00);
        wr(3'h4, 8'h0F);
        for (int i = 0; i < 6; i++)
        begin
            wr(3'h2, rows[i].cb);
            wr(3'h3, rows[i].ff);
            wr(3'h1, rows[i].filt);
            node.send(rows[i].d, rows[i].nb, rows[i].t);
            rd(3'h1, {rows[i].keep, 6'h10, rows[i].filt[0]});
            if (rows[i].keep)
                rd(3'h0, rows[i].exp);
            $display("row %0d done", i);
        end
        wr(3'h2, 8'h14);
        wr(3'h3, 8'h86);
        node.send(9'h111, 9, 1'b1);
        node.send(9'h022, 9, 1'b0);
        rd(3'h2, 8'h16);
        rd(3'h0, 8'h11);
        rd(3'h0, 8'h22);
        rd(3'h1, 8'h20);
        node.send(9'h044, 9, 1'b0);
        wr(3'h2, 8'h04);
        rd(3'h1, 8'h20);
        $display("fifo done");
        wr(3'h1, 8'h01);
        wr(3'h2, 8'h0D);
        wr(3'h0, 8'hC3);
        wr(3'h0, 8'h5A);
        rd(3'h1, 8'h01);
        wr(3'h0, 8'hFF);
        repeat (500) @(posedge clk_sys);
        chk(8'(node.got.size()), 8'h02);
        chk(node.got[0][7:0], 8'hC3);
        chk(node.got[1][7:0], 8'h5A);
        chk({node.got[0][8], node.got[1][8], 6'h00}, 8'hC0);
        rd(3'h1, 8'h61);
        wr(3'h2, 8'h6D);
        @(posedge clk_sys);
        tx_done_irq_ack <= 1'b1;
        #1 chk({4'h0, txd_oe, irq_rx_complete, irq_tx_done, irq_tx_empty}, 8'h0B);
        @(posedge clk_sys);
        tx_done_irq_ack <= 1'b0;
        #1 chk({4'h0, txd_oe, irq_rx_complete, irq_tx_done, irq_tx_empty}, 8'h09);
        wr(3'h1, 8'h41);
        rd(3'h1, 8'h21);
        $display("tx done");
        end_of_test();
    end
endmodule
`default_nettype wire
